// ===== hw/hssc_filter.sv
// Purpose: persistence filter for one comparator level
// Assumes: active is synchronous to ref_clk
// Notes: one pulse per unbroken run of COUNT active cycles
`timescale 1ns/1ns
`default_nettype none
module hssc_filter #(
    parameter int unsigned COUNT = 320
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic active,
    output var  logic hit_q
);
    localparam int W = $clog2(COUNT + 1);
    logic [W-1:0] cnt_q;
    // Run length, saturating so a long run pulses once
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !active) begin
            cnt_q <= '0;
        end else if (cnt_q != W'(COUNT)) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
    // Pulse on the cycle the run reaches COUNT
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hit_q <= 1'b0;
        end else begin
            hit_q <= active && (cnt_q == W'(COUNT - 1));
        end
    end
endmodule
`default_nettype wire

// ===== hw/hssc_pkg.sv
// Purpose: types and shared decode of the switch control
// Assumes: hssc_regs.svh on the include path
// Notes: bus and sensor groups travel as packed structs
`default_nettype none
package hssc_pkg;
`include "hssc_regs.svh"
    // System operating modes
    typedef enum logic [2:0] {
        mode_normal, mode_stop, mode_sleep, mode_restart, mode_failsafe
    } hssc_mode_t;
    // APB request and answer
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } hssc_apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } hssc_apb_rsp_t;
    // Comparator levels and timer levels, one bit per output for the current levels, one per timer for timer
    typedef struct packed {
        logic       supply_ov;
        logic       supply_uv;
        logic [3:0] over_current;
        logic [3:0] low_current;
        logic [1:0] timer;
    } hssc_sense_t;
    // Drive level selected by an output's config field
    function automatic logic hssc_drive(input logic [2:0] cfg,
                                        input logic [1:0] tmr,
                                        input logic [1:0] pg);
        case (cfg)
            `HSSC_CFG_ON:   return 1'b1;
            `HSSC_CFG_TMR1: return tmr[0];
            `HSSC_CFG_TMR2: return tmr[1];
            `HSSC_CFG_PG1:  return pg[0]; // [R21]
            `HSSC_CFG_PG2:  return pg[1]; // [R21]
            default:        return 1'b0;
        endcase
    endfunction
    // Least time in ns to clock cycles, rounded up
    function automatic int unsigned hssc_ns_to_cyc(input int unsigned ns);
        return (ns * (`HSSC_CLK_HZ / 1000000) + 999) / 1000;
    endfunction
endpackage
`default_nettype wire

// ===== hw/hssc_pwm.sv
// Purpose: free running 8-bit pulse generator with two rates
// Assumes: duty and fast are register outputs
// Notes: high for duty/256 of each period, so 0 never goes high
`timescale 1ns/1ns
`default_nettype none
module hssc_pwm #(
    parameter int unsigned STEP_LO = 390,
    parameter int unsigned STEP_HI = 195
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] duty,
    input  wire logic       fast,
    output var  logic       pwm_q
);
    localparam int W = $clog2(STEP_LO);
    logic [W-1:0] pre_q;
    logic [7:0]   phase_q;
    logic [W-1:0] last;
    logic         step;
    assign last = fast ? W'(STEP_HI - 1) : W'(STEP_LO - 1); // [R20]
    assign step = (pre_q >= last);
    // Step prescaler and period phase
    always_ff @(posedge ref_clk) begin
        if (!rst_n || step) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + 1'b1;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            phase_q <= 8'h00;
        end else if (step) begin
            phase_q <= phase_q + 8'h01;
        end
    end
    // Compare against duty
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pwm_q <= 1'b0;
        end else begin
            pwm_q <= (phase_q < duty); // [R24]
        end
    end
endmodule
`default_nettype wire

// ===== hw/hssc_regs.svh
// Purpose: register map, field positions and timing figures of the switch control
// Assumes: 20 MHz reference clock, 32-bit APB data, byte addresses
// Notes: definitions only
`ifndef HSSC_REGS_SVH
`define HSSC_REGS_SVH
// Register byte offsets
`define HSSC_OFF_CFG_A     8'h00
`define HSSC_OFF_CFG_B     8'h04
`define HSSC_OFF_SUP_CTRL  8'h08
`define HSSC_OFF_SUP_STAT  8'h0C
`define HSSC_OFF_OC_STAT   8'h10
`define HSSC_OFF_OL_STAT   8'h14
`define HSSC_OFF_PG1_DUTY  8'h18
`define HSSC_OFF_PG2_DUTY  8'h1C
`define HSSC_OFF_PG_FREQ   8'h20
// Supply control and status bit positions
`define HSSC_BIT_OV_DIS    0
`define HSSC_BIT_UV_DIS    1
`define HSSC_BIT_REC_EN    2
`define HSSC_BIT_OV_FLAG   0
`define HSSC_BIT_UV_FLAG   1
// Output config field: 3 bits, low output at bit 0, high output at bit 4
`define HSSC_CFG_LSB_LO    0
`define HSSC_CFG_LSB_HI    4
`define HSSC_CFG_OFF       3'h0
`define HSSC_CFG_ON        3'h1
`define HSSC_CFG_TMR1      3'h2
`define HSSC_CFG_TMR2      3'h3
`define HSSC_CFG_PG1       3'h4
`define HSSC_CFG_PG2       3'h5
// Reset values
`define HSSC_SUP_CTRL_RST  3'h0
`define HSSC_DUTY_RST      8'h00
`define HSSC_FREQ_RST      2'h0
// Timing
`define HSSC_CLK_HZ        20000000
`define HSSC_OC_FILT_NS    16000
`define HSSC_OL_FILT_NS    64000
`define HSSC_PG_LO_HZ      200
`define HSSC_PG_HI_HZ      400
`define HSSC_PG_STEPS      256
`endif

// ===== hw/hssc_top.sv
// Purpose: control and protection of four high-side outputs behind APB
// Assumes: comparator, timer and mode inputs synchronous to ref_clk
// Notes: zero-wait APB slave; status flags are write-one-to-clear
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "hssc_regs.svh"
// Notes on behaviour
// [R1] Supply over-voltage turns off every output that is on.
// [R2] Over-voltage gone: outputs it stopped return, subject to recovery setting.
// [R3] Supply under-voltage turns off the outputs.
// [R4] Under-voltage gone: outputs it stopped return, subject to recovery setting.
// [R5] Two bits disable over-voltage and under-voltage shutdown separately.
// [R6] Recovery bit set: outputs resume their programmed config after the fault.
// [R7] Recovery bit clear: stopped outputs stay off and their config clears; here they still come on for one cycle when the fault ends.
// [R8] Over- and under-voltage have own status bits; no other flag set.
// [R9] Over-current held past 16 us filter turns that output off.
// [R10] Over-current shutdown sets the output's flag and forces config to 000.
// [R11] Software re-enables by writing config 001 or a timer/pulse choice.
// [R12] Over-current flags never self-clear; software should clear before re-enable.
// [R13] Open load checked only while on; 64 us below threshold sets flag.
// [R14] Open load leaves the output on.
// [R15] Open-load flag holds until software clears it.
// [R16] Protections stay active in stop and sleep modes.
// [R17] Software configures outputs in normal mode before low-power modes.
// [R18] Restart and fail-safe force all outputs off; software re-enables later.
// [R19] Two pulse generators, each with its own 8-bit duty register.
// [R20] Each generator runs at 200 Hz or 400 Hz, chosen per generator.
// [R21] Outputs select timer 1, timer 2 or a generator; pulses start at once; here an output joins the free-running generator mid-period.
// [R22] Software keeps duty at least 4 steps at 400 Hz, 2 at 200 Hz.
// [R23] Stop and sleep keep the config and ignore writes to it.
// [R24] A generator is high for duty/256 of every period.
module hssc_top import hssc_pkg::*; #(
    parameter int unsigned OC_CYC  = hssc_ns_to_cyc(`HSSC_OC_FILT_NS),
    parameter int unsigned OL_CYC  = hssc_ns_to_cyc(`HSSC_OL_FILT_NS),
    parameter int unsigned STEP_LO = `HSSC_CLK_HZ / (`HSSC_PG_LO_HZ * `HSSC_PG_STEPS),
    parameter int unsigned STEP_HI = `HSSC_CLK_HZ / (`HSSC_PG_HI_HZ * `HSSC_PG_STEPS)
) (
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    input  wire hssc_apb_req_t apb_req,
    output var  hssc_apb_rsp_t apb_rsp,
    input  wire hssc_sense_t   sense,
    input  wire hssc_mode_t    sys_mode,
    output var  logic [3:0]    high_side_output
);
    // Register state
    logic [3:0][2:0] cfg_q;
    logic            ov_dis_q;
    logic            uv_dis_q;
    logic            rec_en_q;
    logic            ov_flag_q;
    logic            uv_flag_q;
    logic [3:0]      oc_flag_q;
    logic [3:0]      ol_flag_q;
    logic [7:0]      duty1_q;
    logic [7:0]      duty2_q;
    logic [1:0]      fast_q;
    logic            fault_q;
    logic [3:0]      victim_q;

    // Bus phase decode
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        setup;
    logic        wr_fire;
    assign addr    = apb_req.paddr;
    assign wdata   = apb_req.pwdata;
    assign setup   = apb_req.psel && !apb_req.penable;
    assign wr_fire = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready;

    // Write strobe for one offset
    function automatic logic wr_at(input logic [7:0] off);
        return wr_fire && (addr == off);
    endfunction

    // Write-one-to-clear mask of a status register
    function automatic logic [3:0] clr_of(input logic [7:0] off);
        return wr_at(off) ? wdata[3:0] : 4'h0;
    endfunction

    // Mode and supply fault conditions
    logic low_power;
    logic forced_off;
    logic ov_act;
    logic uv_act;
    logic fault_now;
    logic fault_end;
    assign low_power  = (sys_mode == mode_stop) || (sys_mode == mode_sleep);
    assign forced_off = (sys_mode == mode_restart) || (sys_mode == mode_failsafe);
    assign ov_act     = sense.supply_ov && !ov_dis_q; // [R1] [R5] [R16]
    assign uv_act     = sense.supply_uv && !uv_dis_q; // [R3] [R5] [R16]
    assign fault_now  = ov_act || uv_act;
    assign fault_end  = fault_q && !fault_now;

    // Current filters, run only while the output is driven
    logic [3:0] oc_hit;
    logic [3:0] ol_hit;
    for (genvar i = 0; i < 4; i++) begin : g_filt
        hssc_filter #(.COUNT(OC_CYC)) u_oc (
            .ref_clk (ref_clk),
            .rst_n   (rst_n),
            .active  (sense.over_current[i] && high_side_output[i]), // [R9] [R16]
            .hit_q   (oc_hit[i])
        );
        hssc_filter #(.COUNT(OL_CYC)) u_ol (
            .ref_clk (ref_clk),
            .rst_n   (rst_n),
            .active  (sense.low_current[i] && high_side_output[i]), // [R13] [R16]
            .hit_q   (ol_hit[i])
        );
    end

    // Pulse generators, free running
    logic [1:0] pg;
    hssc_pwm #(.STEP_LO(STEP_LO), .STEP_HI(STEP_HI)) u_pg1 (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .duty    (duty1_q), // [R19]
        .fast    (fast_q[0]),
        .pwm_q   (pg[0])
    );
    hssc_pwm #(.STEP_LO(STEP_LO), .STEP_HI(STEP_HI)) u_pg2 (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .duty    (duty2_q), // [R19]
        .fast    (fast_q[1]),
        .pwm_q   (pg[1])
    );

    // Output config fields with protection and mode overrides
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cfg_q <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (forced_off) begin
                    cfg_q[i] <= `HSSC_CFG_OFF; // [R18]
                end else if (oc_hit[i]) begin
                    cfg_q[i] <= `HSSC_CFG_OFF; // [R10]
                end else if (fault_end && !rec_en_q && victim_q[i]) begin
                    cfg_q[i] <= `HSSC_CFG_OFF; // [R7]
                end else if (!low_power && wr_at(i < 2 ? `HSSC_OFF_CFG_A
                                                       : `HSSC_OFF_CFG_B)) begin // [R23]
                    cfg_q[i] <= wdata[((i % 2 == 1) ? `HSSC_CFG_LSB_HI
                                                    : `HSSC_CFG_LSB_LO) +: 3];
                end
            end
        end
    end

    // Outputs stopped by a supply fault, remembered until it ends
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fault_q  <= 1'b0;
            victim_q <= 4'h0;
        end else begin
            fault_q <= fault_now;
            for (int i = 0; i < 4; i++) begin
                victim_q[i] <= fault_now && (victim_q[i] || (cfg_q[i] != `HSSC_CFG_OFF));
            end
        end
    end

    // Output drive; config returns to force once faults clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            high_side_output <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                high_side_output[i] <= hssc_drive(cfg_q[i], sense.timer, pg) // [R2] [R4] [R6]
                                       && !fault_now // [R1] [R3]
                                       && !forced_off // [R18]
                                       && !oc_hit[i]; // [R9] [R14]
            end
        end
    end

    // Control registers, frozen in stop and sleep modes
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            {rec_en_q, uv_dis_q, ov_dis_q} <= `HSSC_SUP_CTRL_RST;
            duty1_q <= `HSSC_DUTY_RST;
            duty2_q <= `HSSC_DUTY_RST;
            fast_q  <= `HSSC_FREQ_RST;
        end else if (!low_power) begin // [R23]
            if (wr_at(`HSSC_OFF_SUP_CTRL)) begin
                ov_dis_q <= wdata[`HSSC_BIT_OV_DIS]; // [R5]
                uv_dis_q <= wdata[`HSSC_BIT_UV_DIS]; // [R5]
                rec_en_q <= wdata[`HSSC_BIT_REC_EN];
            end
            if (wr_at(`HSSC_OFF_PG1_DUTY)) begin
                duty1_q <= wdata[7:0]; // [R19]
            end
            if (wr_at(`HSSC_OFF_PG2_DUTY)) begin
                duty2_q <= wdata[7:0]; // [R19]
            end
            if (wr_at(`HSSC_OFF_PG_FREQ)) begin
                fast_q <= wdata[1:0]; // [R20]
            end
        end
    end

    // Sticky status flags; a new event wins over a clear
    logic [3:0] sup_clr;
    logic [3:0] oc_clr;
    logic [3:0] ol_clr;
    assign sup_clr = clr_of(`HSSC_OFF_SUP_STAT);
    assign oc_clr  = clr_of(`HSSC_OFF_OC_STAT);
    assign ol_clr  = clr_of(`HSSC_OFF_OL_STAT);
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ov_flag_q <= 1'b0;
            uv_flag_q <= 1'b0;
            oc_flag_q <= 4'h0;
            ol_flag_q <= 4'h0;
        end else begin
            ov_flag_q <= sense.supply_ov || (ov_flag_q && !sup_clr[`HSSC_BIT_OV_FLAG]); // [R8]
            uv_flag_q <= sense.supply_uv || (uv_flag_q && !sup_clr[`HSSC_BIT_UV_FLAG]); // [R8]
            oc_flag_q <= oc_hit | (oc_flag_q & ~oc_clr); // [R10] [R12]
            ol_flag_q <= ol_hit | (ol_flag_q & ~ol_clr); // [R13] [R15]
        end
    end

    // Read data and address check
    logic [31:0] rdata;
    logic        unmapped;
    always_comb begin
        rdata    = 32'h0000_0000;
        unmapped = 1'b0;
        case (addr)
            `HSSC_OFF_CFG_A:    rdata = {24'h0, 1'b0, cfg_q[1], 1'b0, cfg_q[0]};
            `HSSC_OFF_CFG_B:    rdata = {24'h0, 1'b0, cfg_q[3], 1'b0, cfg_q[2]};
            `HSSC_OFF_SUP_CTRL: rdata = {29'h0, rec_en_q, uv_dis_q, ov_dis_q};
            `HSSC_OFF_SUP_STAT: rdata = {30'h0, uv_flag_q, ov_flag_q};
            `HSSC_OFF_OC_STAT:  rdata = {28'h0, oc_flag_q};
            `HSSC_OFF_OL_STAT:  rdata = {28'h0, ol_flag_q};
            `HSSC_OFF_PG1_DUTY: rdata = {24'h0, duty1_q};
            `HSSC_OFF_PG2_DUTY: rdata = {24'h0, duty2_q};
            `HSSC_OFF_PG_FREQ:  rdata = {30'h0, fast_q};
            default:            unmapped = 1'b1;
        endcase
    end

    // APB answer: ready in every access phase, data captured at setup
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            apb_rsp <= '0;
        end else begin
            apb_rsp.pready <= setup;
            if (setup) begin
                apb_rsp.prdata  <= apb_req.pwrite ? 32'h0000_0000 : rdata;
                apb_rsp.pslverr <= unmapped;
            end
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Run length of an over-current on output 3
    int unsigned oc2_run_q;
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !(sense.over_current[2] && high_side_output[2])) begin
            oc2_run_q <= 0;
        end else if (oc2_run_q < OC_CYC) begin
            oc2_run_q <= oc2_run_q + 1;
        end
    end

    sequence s_fault_end;
        fault_q && !fault_now;
    endsequence
    sequence s_out0_on_normal;
        cfg_q[0] == `HSSC_CFG_ON && sys_mode == mode_normal && !oc_hit[0];
    endsequence

    a_ov_shutdown: // [R1]
        assert property (ov_act |=> high_side_output == 4'h0)
        else $error("output driven during over-voltage");
    a_uv_shutdown: // [R3]
        assert property (uv_act |=> high_side_output == 4'h0)
        else $error("output driven during under-voltage");
    a_ov_disabled: // [R5]
        assert property ((sense.supply_ov && ov_dis_q && !uv_act) ##0 s_out0_on_normal
                         |=> high_side_output[0])
        else $error("disabled over-voltage shutdown still acted");
    a_fault_keep_off: // [R7]
        assert property (s_fault_end ##0 (!rec_en_q && victim_q[0])
                         |=> cfg_q[0] == `HSSC_CFG_OFF)
        else $error("config not cleared after supply fault");
    a_fault_restore: // [R2] [R4] [R6]
        assert property (s_fault_end ##0 rec_en_q ##0 s_out0_on_normal
                         |=> high_side_output[0])
        else $error("output not restored after supply fault");
    a_oc_latch: // [R10]
        assert property (oc_hit[2] |=> oc_flag_q[2] && cfg_q[2] == `HSSC_CFG_OFF
                                        && !high_side_output[2])
        else $error("over-current shutdown incomplete");
    a_oc_filter: // [R9]
        assert property (oc_hit[2] |-> oc2_run_q == OC_CYC)
        else $error("over-current filter length wrong");
    a_ol_flag: // [R13]
        assert property (ol_hit[3] |=> ol_flag_q[3])
        else $error("open-load flag not set");
    a_ol_stays_on: // [R14]
        assert property ((ol_hit[3] && !fault_now && !forced_off && !oc_hit[3])
                         && cfg_q[3] == `HSSC_CFG_ON |=> high_side_output[3])
        else $error("open load turned the output off");
    a_flag_hold: // [R15]
        assert property ((ol_flag_q[3] && !ol_clr[3]) |=> ol_flag_q[3])
        else $error("open-load flag lost without a clear");
    // Flag, supply disable, filter, generator and mode checks
    a_ov_flag: // [R8]
        assert property (sense.supply_ov |=> ov_flag_q)
        else $error("over-voltage flag missed");
    a_uv_flag: // [R8]
        assert property (sense.supply_uv |=> uv_flag_q)
        else $error("under-voltage flag missed");
    a_uv_disabled: // [R5]
        assert property ((sense.supply_uv && uv_dis_q && !ov_act) ##0 s_out0_on_normal
                         |=> high_side_output[0])
        else $error("disabled under-voltage shutdown acted");
    a_oc_hold: // [R12]
        assert property ((oc_flag_q[2] && !oc_clr[2]) |=> oc_flag_q[2])
        else $error("over-current flag lost");
    a_ol_when_on: // [R13]
        assert property (ol_hit[3] |-> $past(high_side_output[3]))
        else $error("open load flagged while off");
    a_gen_idle: // [R24]
        assert property ($past(duty1_q) == 8'h00 |-> !pg[0])
        else $error("generator high at zero duty");
    a_mode_off: // [R18]
        assert property (forced_off |=> high_side_output == 4'h0 && cfg_q == '0)
        else $error("output alive in restart or fail-safe");
    a_low_pwr_lock: // [R23]
        assert property ((low_power && oc_hit == 4'h0 && !fault_end) |=> $stable(cfg_q))
        else $error("config changed in a low-power mode");
endmodule
`default_nettype wire

// ===== verification/high_side_switch_control_bench.sv
// Purpose: self-checking bench of the switch control over APB
// Assumes: zero-wait APB slave, short filter and step parameters
// Notes: expected counts follow from the parameters set here
`timescale 1ns/1ns
`default_nettype none
`include "hssc_regs.svh"
module high_side_switch_control_bench import hssc_pkg::*;;
    localparam int unsigned OC_N = 4;
    localparam int unsigned OL_N = 8;
    logic          ref_clk   = 1'b0;
    logic          rst_n     = 1'b0;
    hssc_apb_req_t apb_req   = '0;
    hssc_apb_rsp_t apb_rsp;
    hssc_sense_t   sense;
    hssc_mode_t    sys_mode  = mode_normal;
    logic          ov        = 1'b0;
    logic          uv        = 1'b0;
    logic [1:0]    tmr       = 2'h0;
    logic [3:0]    short_cmd = 4'h0;
    logic [3:0]    open_cmd  = 4'h0;
    logic [3:0]    oc_w;
    logic [3:0]    lc_w;
    logic [3:0]    hso;
    logic [31:0]   rd;
    logic          err;
    int            failures  = 0;
    int            cmp_count = 0;
    int            c0;
    int            c1;
    logic [2:0]    codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
    hssc_mode_t    lp [2]    = '{mode_stop, mode_sleep};
    hssc_mode_t    rs [2]    = '{mode_restart, mode_failsafe};

    // Clock and sensor bundle
    always #25 ref_clk = ~ref_clk;
    assign sense = {ov, uv, oc_w, lc_w, tmr};

    hssc_top #(.OC_CYC(OC_N), .OL_CYC(OL_N), .STEP_LO(4), .STEP_HI(2)) u_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .sense(sense), .sys_mode(sys_mode), .high_side_output(hso));
    hssc_load_model u_load (.drive(hso), .short_cmd(short_cmd), .open_cmd(open_cmd),
        .over_current(oc_w), .low_current(lc_w));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        apb_req.psel <= 1'b1;
        apb_req.pwrite <= wr;
        apb_req.paddr <= a;
        apb_req.pwdata <= d;
        @(posedge ref_clk);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 50);
        chk("pready", 32'h1, 32'(apb_rsp.pready));
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("register", e, rd);
    endtask
    task automatic oc(input logic [3:0] e);
        cyc(3);
        chk("outputs", 32'(e), 32'(hso));
    endtask
    task automatic final_report;
        if (failures == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        cyc(30000);
        failures++;
        final_report();
    end

    // Main sequence
    initial begin
        cyc(20);
        rst_n <= 1'b1;
        for (int a = 0; a <= 8; a++) begin
            rc(8'(a * 4), 32'h0);
            chk("slverr", 32'h0, 32'(err));
        end
        rc(8'h24, 32'h0);
        chk("slverr", 32'h1, 32'(err));
        // Supply faults with recovery on
        w(`HSSC_OFF_SUP_CTRL, 32'h4);
        w(`HSSC_OFF_CFG_A, 32'h11);
        oc(4'h3);
        ov <= 1'b1;
        oc(4'h0);
        rc(`HSSC_OFF_SUP_STAT, 32'h1);
        rc(`HSSC_OFF_OC_STAT, 32'h0);
        rc(`HSSC_OFF_OL_STAT, 32'h0);
        ov <= 1'b0;
        oc(4'h3);
        uv <= 1'b1;
        oc(4'h0);
        uv <= 1'b0;
        oc(4'h3);
        w(`HSSC_OFF_SUP_STAT, 32'h3);
        rc(`HSSC_OFF_SUP_STAT, 32'h0);
        // Recovery off clears the stopped configs
        w(`HSSC_OFF_SUP_CTRL, 32'h0);
        uv <= 1'b1;
        cyc(3);
        uv <= 1'b0;
        oc(4'h0);
        rc(`HSSC_OFF_CFG_A, 32'h0);
        // Shutdown disables, both together, then over-voltage alone
        w(`HSSC_OFF_SUP_CTRL, 32'h3);
        w(`HSSC_OFF_CFG_A, 32'h11);
        ov <= 1'b1;
        uv <= 1'b1;
        oc(4'h3);
        ov <= 1'b0;
        w(`HSSC_OFF_SUP_CTRL, 32'h5);
        oc(4'h0);
        uv <= 1'b0;
        oc(4'h3);
        w(`HSSC_OFF_SUP_STAT, 32'h3);
        // Over-current filter, one cycle short then full
        w(`HSSC_OFF_SUP_CTRL, 32'h4);
        w(`HSSC_OFF_CFG_B, 32'h1);
        short_cmd <= 4'h4;
        cyc(OC_N - 1);
        short_cmd <= 4'h0;
        oc(4'h7);
        short_cmd <= 4'h4;
        cyc(OC_N + 3);
        short_cmd <= 4'h0;
        chk("outputs", 32'h3, 32'(hso));
        rc(`HSSC_OFF_OC_STAT, 32'h4);
        rc(`HSSC_OFF_CFG_B, 32'h0);
        w(`HSSC_OFF_CFG_B, 32'h1);
        oc(4'h7);
        rc(`HSSC_OFF_OC_STAT, 32'h4);
        w(`HSSC_OFF_OC_STAT, 32'h4);
        rc(`HSSC_OFF_OC_STAT, 32'h0);
        // Open load on output 4
        w(`HSSC_OFF_CFG_B, 32'h11);
        open_cmd <= 4'h8;
        cyc(OL_N - 1);
        open_cmd <= 4'h0;
        rc(`HSSC_OFF_OL_STAT, 32'h0);
        open_cmd <= 4'h8;
        cyc(OL_N + 3);
        chk("outputs", 32'hF, 32'(hso));
        open_cmd <= 4'h0;
        rc(`HSSC_OFF_OL_STAT, 32'h8);
        w(`HSSC_OFF_OL_STAT, 32'h8);
        rc(`HSSC_OFF_OL_STAT, 32'h0);
        // Low-power modes keep config and protections
        foreach (lp[i]) begin
            sys_mode <= lp[i];
            w(`HSSC_OFF_CFG_A, 32'h0);
            rc(`HSSC_OFF_CFG_A, 32'h11);
            ov <= 1'b1;
            oc(4'h0);
            ov <= 1'b0;
            short_cmd <= 4'h4;
            cyc(OC_N + 3);
            short_cmd <= 4'h0;
            chk("outputs", 32'hB, 32'(hso));
            sys_mode <= mode_normal;
            w(`HSSC_OFF_CFG_B, 32'h11);
            w(`HSSC_OFF_OC_STAT, 32'h4);
        end
        // Restart and fail-safe force everything off
        foreach (rs[i]) begin
            sys_mode <= rs[i];
            oc(4'h0);
            rc(`HSSC_OFF_CFG_A, 32'h0);
            sys_mode <= mode_normal;
            w(`HSSC_OFF_CFG_A, 32'h1);
            oc(4'h1);
        end
        // Config codes other than the generator codes 4 and 5 against both timer levels
        for (int t = 1; t <= 2; t++) begin
            tmr <= 2'(t);
            foreach (codes[i]) begin
                w(`HSSC_OFF_CFG_A, 32'(codes[i]));
                cyc(3);
                chk("output1", 32'(codes[i] == 3'h1 || codes[i] == 3'(t + 1)),
                    32'(hso[0]));
            end
        end
        // Pulse generators: counts over whole periods
        w(`HSSC_OFF_PG1_DUTY, 32'h40);
        w(`HSSC_OFF_PG2_DUTY, 32'h60);
        w(`HSSC_OFF_PG_FREQ, 32'h2);
        w(`HSSC_OFF_CFG_A, 32'h54);
        for (int p = 0; p < 2; p++) begin
            cyc(1024);
            c0 = 0;
            c1 = 0;
            repeat (1024 / (p + 1)) begin
                @(posedge ref_clk);
                c0 += int'(hso[0]);
                c1 += int'(hso[1]);
            end
            chk("pwm1 high", 32'd256 / (p + 1), 32'(c0));
            if (p == 0) begin
                chk("pwm2 high", 32'd384, 32'(c1));
                w(`HSSC_OFF_PG_FREQ, 32'h3);
            end
        end
        rc(`HSSC_OFF_PG_FREQ, 32'h3);
        final_report();
    end
endmodule
`default_nettype wire

// ===== verification/hssc_load_model.sv
// Purpose: behavioural loads behind the four switch outputs
// Assumes: drive is the registered output level of the switch block
// Notes: short and open commands come from the bench
`timescale 1ns/1ns
`default_nettype none
module hssc_load_model import hssc_pkg::*; (
    input  wire logic [3:0] drive,
    input  wire logic [3:0] short_cmd,
    input  wire logic [3:0] open_cmd,
    output logic      [3:0] over_current,
    output logic      [3:0] low_current
);
    // No current flows while off, so low current reads high then
    assign over_current = drive & short_cmd;
    assign low_current  = ~drive | open_cmd;
endmodule
`default_nettype wire
